// file: hdl/uartad_rx.sv
// What this block does
// R1: bit rate from 16-bit divisor pair plus high-speed and wide-divisor selects.
// R2: works only with port enable set and synchronous select clear.
// R3: characters accepted only while continuous receive enable is set.
// R4: nine-bit select captures nine data bits; ninth kept apart from byte.
// R5: address-detect enable switches into address mode, used with nine bits.
// R6: in address mode, flag set only for characters with ninth bit one.
// R7: interrupt request only when flag and receive interrupt enable both set.
// R8: in address mode, every buffered character shows ninth bit as one.
// R9: status shows error flags and ninth bit of buffered character.
// R10: data read returns lower byte of oldest character; software matches.
// R11: overrun stays set until continuous receive enable is cleared.
// R12: with address detect cleared, every character arriving with buffer room and no overrun is buffered and flagged.
// R13: low start bit, eight or nine data bits, high stop, idle high.
// R14: data least significant bit first; no hardware parity.
// R15: in address mode, ninth-bit-zero characters are dropped with no flag.
`timescale 1ns/1ps
`default_nettype none

module uartad_rx
	import uartad_pkg::*;
(
	input wire logic i_clk, // 10 MHz system clock
	input wire logic i_rst, // synchronous reset, active high
	input wire logic i_serial_receive_pin, // serial line, idles high
	input wire logic [7:0] i_baud_divisor_high, // divisor upper byte
	input wire logic [7:0] i_baud_divisor_low, // divisor lower byte
	input wire logic i_high_speed_baud_select, // fewer ticks per bit
	input wire logic i_wide_divisor_select, // use the full 16-bit divisor
	input wire logic i_serial_port_enable, // port on
	input wire logic i_sync_mode_select, // must be low for async
	input wire logic i_continuous_receive_enable, // receiver on
	input wire logic i_nine_bit_receive_select, // nine data bits
	input wire logic i_address_detect_enable, // address mode
	input wire logic i_receive_irq_enable, // gates the request
	input wire logic i_data_read, // strobe: software reads data register
	output logic [7:0] o_receive_data, // lower byte of oldest character
	output logic o_ninth_bit, // ninth bit of oldest character
	output logic o_framing_error, // stop bit of oldest character was low
	output logic o_overrun_error_flag, // sticky overrun
	output logic o_receive_irq_flag, // buffer holds a character
	output logic o_receive_irq, // interrupt request
	output logic o_receive_idle // receiver between characters
);

	typedef struct packed {
		uartad_state_t state;
		logic [6:0] tick_cnt;
		logic [3:0] bit_cnt;
		logic [8:0] shift;
		logic overrun;
		logic irq;
		logic idle;
	} uartad_rx_reg_t;

	uartad_rx_reg_t r;
	uartad_rx_reg_t next_r;

	logic active;
	logic addr_mode;
	logic baud_tick;
	logic [UARTAD_DIV_W-1:0] divisor;
	logic [6:0] ticks_per_bit;
	logic [6:0] half_bit;
	logic [3:0] data_bits;
	logic deliver;
	logic keep;
	logic ferr;
	logic [7:0] rx_byte;
	logic rx_ninth;
	logic push;
	logic buf_ready;
	logic buf_valid;
	logic [UARTAD_ENTRY_W-1:0] entry_in;
	logic [UARTAD_ENTRY_W-1:0] entry_out;

	// port runs only with enable set, async selected and reception on
	assign active = i_serial_port_enable && !i_sync_mode_select // [R2]
		&& i_continuous_receive_enable; // [R3]

	// address filtering only means something once nine bits are captured
	assign addr_mode = i_address_detect_enable && i_nine_bit_receive_select; // [R5]

	// narrow divisor uses only the low byte
	assign divisor = i_wide_divisor_select ? // [R1]
		{i_baud_divisor_high, i_baud_divisor_low} :
		{8'h00, i_baud_divisor_low};

	// ticks per bit from the two speed selects
	always_comb
	begin
		case ({i_wide_divisor_select, i_high_speed_baud_select}) // [R1]
			2'b00: ticks_per_bit = UARTAD_TPB_SLOW;
			2'b11: ticks_per_bit = UARTAD_TPB_FAST;
			default: ticks_per_bit = UARTAD_TPB_MID;
		endcase
	end

	assign half_bit = ticks_per_bit >> 1;
	assign data_bits = i_nine_bit_receive_select ? UARTAD_BITS_NINE :
		UARTAD_BITS_EIGHT; // [R4]

	uartad_baud u_baud (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_run(active),
		.i_divisor(divisor),
		.o_tick(baud_tick)
	);

	// eight-bit characters end one place high in the shift register
	assign rx_byte = i_nine_bit_receive_select ? r.shift[7:0] : // [R4]
		r.shift[8:1];
	assign rx_ninth = i_nine_bit_receive_select && r.shift[8]; // [R4]
	assign ferr = !i_serial_receive_pin; // [R13]

	// the stop bit is sampled in its middle; that ends the character;
	// a stale tick in the cycle reception drops must not store anything
	assign deliver = (r.state == UARTAD_ST_STOP) && baud_tick && active // [R3]
		&& (r.tick_cnt == ticks_per_bit - 7'h01);

	// address mode drops characters whose ninth bit is zero
	assign keep = !(addr_mode && !rx_ninth); // [R6] [R8] [R12] [R15]

	// while overrun stands nothing more enters the buffer
	assign push = deliver && keep && !r.overrun && buf_ready; // [R11]

	always_comb
	begin
		entry_in = '0;
		entry_in[7:0] = rx_byte; // [R10]
		entry_in[UARTAD_ENT_NINTH] = rx_ninth; // [R9]
		entry_in[UARTAD_ENT_FERR] = ferr; // [R9]
	end

	uartad_buf u_buf (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_valid(push),
		.o_ready(buf_ready),
		.i_data(entry_in),
		.o_valid(buf_valid),
		.o_data(entry_out),
		.i_ready(i_data_read)
	);

	// receive state machine, sampling at mid-bit on baud ticks
	always_comb
	begin
		next_r = r;
		next_r.irq = buf_valid && i_receive_irq_enable; // [R7]
		if (!active)
		begin
			next_r.state = UARTAD_ST_IDLE;
			next_r.tick_cnt = '0;
			next_r.bit_cnt = '0;
		end
		else
		begin
			case (r.state)
				UARTAD_ST_IDLE:
				begin
					// a low line starts a character
					if (!i_serial_receive_pin) // [R13]
					begin
						next_r.state = UARTAD_ST_START;
						next_r.tick_cnt = '0;
						next_r.bit_cnt = '0;
					end
				end
				UARTAD_ST_START:
				begin
					// a start bit gone high at mid-bit was a glitch
					if (baud_tick)
					begin
						next_r.tick_cnt = r.tick_cnt + 7'h01;
						if (r.tick_cnt == half_bit - 7'h01)
						begin
							next_r.tick_cnt = '0;
							next_r.state = i_serial_receive_pin ?
								UARTAD_ST_IDLE : UARTAD_ST_DATA; // [R13]
						end
					end
				end
				UARTAD_ST_DATA:
				begin
					if (baud_tick)
					begin
						next_r.tick_cnt = r.tick_cnt + 7'h01;
						if (r.tick_cnt == ticks_per_bit - 7'h01)
						begin
							next_r.tick_cnt = '0;
							// shift in from the top so the first bit ends lowest
							next_r.shift = {i_serial_receive_pin,
								r.shift[8:1]}; // [R14]
							next_r.bit_cnt = r.bit_cnt + 4'h1;
							if (r.bit_cnt == data_bits - 4'h1) // [R4]
								next_r.state = UARTAD_ST_STOP;
						end
					end
				end
				UARTAD_ST_STOP:
				begin
					if (baud_tick)
					begin
						next_r.tick_cnt = r.tick_cnt + 7'h01;
						if (deliver)
						begin
							next_r.tick_cnt = '0;
							next_r.state = UARTAD_ST_IDLE;
						end
					end
				end
				default:
				begin
					next_r.state = UARTAD_ST_IDLE;
				end
			endcase
		end
		// a kept character with no room is lost and marks overrun
		if (deliver && keep && !buf_ready)
			next_r.overrun = 1'b1;
		// only dropping the receive enable clears it; no event can coincide
		if (!i_continuous_receive_enable)
			next_r.overrun = 1'b0; // [R11]
		next_r.idle = (next_r.state == UARTAD_ST_IDLE);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			r <= '0;
			r.idle <= 1'b1;
		end
		else
			r <= next_r;
	end

	// data, ninth bit and framing error come from the buffer head registers; overrun, flag, request and idle do not
	assign o_receive_data = entry_out[7:0]; // [R10]
	assign o_ninth_bit = entry_out[UARTAD_ENT_NINTH]; // [R9]
	assign o_framing_error = entry_out[UARTAD_ENT_FERR]; // [R9]
	assign o_overrun_error_flag = r.overrun;
	assign o_receive_irq_flag = buf_valid; // [R6] [R12]
	assign o_receive_irq = r.irq;
	assign o_receive_idle = r.idle;

	// request follows flag and enable one clock later
	AST_IRQ_GATED: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
		o_receive_irq |-> $past(buf_valid) && $past(i_receive_irq_enable))
		else $error("irq raised without flag and enable");

	// a disabled port returns to idle
	AST_PORT_OFF: assert property (@(posedge i_clk) disable iff (i_rst) // [R2]
		!(i_serial_port_enable && !i_sync_mode_select)
		|=> r.state == UARTAD_ST_IDLE)
		else $error("receiver busy while port disabled");

	// nothing enters the buffer without receive enable
	AST_NO_CONTINUOUS_RECEIVE_ENABLE_PUSH: assert property (@(posedge i_clk) disable iff (i_rst) // [R3]
		push |-> i_continuous_receive_enable && active)
		else $error("character stored while reception disabled");

	// address mode stores only ninth-bit-one characters
	AST_ADDR_NINTH: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
		push && addr_mode |-> entry_in[UARTAD_ENT_NINTH])
		else $error("address mode stored a ninth-bit-zero character");

	// ninth-bit-zero characters vanish in address mode
	AST_ADDR_DROP: assert property (@(posedge i_clk) disable iff (i_rst) // [R15]
		deliver && addr_mode && !rx_ninth |-> !push ##1 !r.overrun || $past(r.overrun))
		else $error("dropped character had an effect");

	// without address detect every character with room and no overrun is stored
	AST_PASS_ALL: assert property (@(posedge i_clk) disable iff (i_rst) // [R12]
		deliver && !i_address_detect_enable && !r.overrun && buf_ready |-> push)
		else $error("character lost with address detect off");

	// overrun holds while enable stays, clears when it drops
	AST_OVERRUN_ERROR_FLAG_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
		r.overrun && i_continuous_receive_enable |=> r.overrun)
		else $error("overrun cleared while receive enabled");

	AST_OVERRUN_ERROR_FLAG_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
		!i_continuous_receive_enable |=> !r.overrun)
		else $error("overrun survived receive disable");

	// eight-bit mode never reports a ninth bit
	AST_EIGHT_BIT: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
		push && !i_nine_bit_receive_select |-> !entry_in[UARTAD_ENT_NINTH])
		else $error("ninth bit set in eight-bit mode");

	// character ends only after the full count of data bits
	AST_BIT_COUNT: assert property (@(posedge i_clk) disable iff (i_rst) // [R13]
		deliver |-> r.bit_cnt == data_bits)
		else $error("stop bit reached with wrong bit count");

	// data bits fill from the top, so each sample lands at bit 8
	AST_LSB_FIRST: assert property (@(posedge i_clk) disable iff (i_rst) // [R14]
		r.state == UARTAD_ST_DATA && baud_tick
		&& r.tick_cnt == ticks_per_bit - 7'h01 && active
		|=> r.shift[8] == $past(i_serial_receive_pin)
		&& r.shift[7:0] == $past(r.shift[8:1]))
		else $error("data bit not shifted in lsb first");

endmodule : uartad_rx

`default_nettype wire

// file: hdl/uartad_pkg.sv
package uartad_pkg;

	// widths of the divisor pair, the data byte and one buffer entry
	localparam int unsigned UARTAD_DIV_W = 16;
	localparam int unsigned UARTAD_BYTE_W = 8;
	localparam int unsigned UARTAD_ENTRY_W = 10;

	// field positions inside a buffer entry
	localparam int unsigned UARTAD_ENT_NINTH = 8;
	localparam int unsigned UARTAD_ENT_FERR = 9;

	// baud ticks per bit time, chosen by the two speed select bits
	localparam logic [6:0] UARTAD_TPB_SLOW = 7'h40;
	localparam logic [6:0] UARTAD_TPB_MID = 7'h10;
	localparam logic [6:0] UARTAD_TPB_FAST = 7'h04;

	// data bits per character
	localparam logic [3:0] UARTAD_BITS_EIGHT = 4'h8;
	localparam logic [3:0] UARTAD_BITS_NINE = 4'h9;

	// buffer occupancy
	localparam logic [1:0] UARTAD_BUF_EMPTY = 2'h0;
	localparam logic [1:0] UARTAD_BUF_FULL = 2'h2;

	typedef enum logic [1:0] {
		UARTAD_ST_IDLE = 2'b00,
		UARTAD_ST_START = 2'b01,
		UARTAD_ST_DATA = 2'b10,
		UARTAD_ST_STOP = 2'b11
	} uartad_state_t;

endpackage : uartad_pkg

// file: hdl/uartad_baud.sv
`timescale 1ns/1ps
`default_nettype none

module uartad_baud
	import uartad_pkg::*;
(
	input wire logic i_clk, // system clock
	input wire logic i_rst, // synchronous reset, active high
	input wire logic i_run, // divider runs while high
	input wire logic [UARTAD_DIV_W-1:0] i_divisor, // reload value
	output logic o_tick // one-cycle pulse every divisor+1 clocks
);

	typedef struct packed {
		logic [UARTAD_DIV_W-1:0] cnt;
		logic tick;
	} uartad_baud_reg_t;

	uartad_baud_reg_t r;
	uartad_baud_reg_t next_r;

	// down counter; reloads while stopped so a new divisor takes effect at once
	always_comb
	begin
		next_r = r;
		next_r.tick = 1'b0;
		if (!i_run)
		begin
			next_r.cnt = i_divisor;
		end
		else if (r.cnt == '0)
		begin
			next_r.cnt = i_divisor;
			next_r.tick = 1'b1;
		end
		else
		begin
			next_r.cnt = r.cnt - 1'b1;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			r <= '0;
		else
			r <= next_r;
	end

	assign o_tick = r.tick;

endmodule : uartad_baud

`default_nettype wire

// file: hdl/uartad_buf.sv
`timescale 1ns/1ps
`default_nettype none

module uartad_buf
	import uartad_pkg::*;
(
	input wire logic i_clk, // system clock
	input wire logic i_rst, // synchronous reset, active high
	input wire logic i_valid, // writer offers an entry
	output logic o_ready, // buffer has room
	input wire logic [UARTAD_ENTRY_W-1:0] i_data, // entry in
	output logic o_valid, // oldest entry present
	output logic [UARTAD_ENTRY_W-1:0] o_data, // oldest entry
	input wire logic i_ready // reader takes the oldest entry
);

	typedef struct packed {
		logic [UARTAD_ENTRY_W-1:0] head;
		logic [UARTAD_ENTRY_W-1:0] tail;
		logic [1:0] cnt;
		logic valid;
		logic ready;
	} uartad_buf_reg_t;

	uartad_buf_reg_t r;
	uartad_buf_reg_t next_r;
	logic pop;
	logic push;

	// pop first, then push; a full buffer refuses even if popped this cycle
	always_comb
	begin
		next_r = r;
		pop = r.valid && i_ready;
		push = i_valid && r.ready;
		if (pop)
		begin
			next_r.head = r.tail;
			next_r.cnt = r.cnt - 1'b1;
		end
		if (push)
		begin
			if (next_r.cnt == UARTAD_BUF_EMPTY)
				next_r.head = i_data;
			else
				next_r.tail = i_data;
			next_r.cnt = next_r.cnt + 1'b1;
		end
		next_r.valid = next_r.cnt != UARTAD_BUF_EMPTY;
		next_r.ready = next_r.cnt != UARTAD_BUF_FULL;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			r <= '0;
			r.ready <= 1'b1;
		end
		else
			r <= next_r;
	end

	assign o_ready = r.ready;
	assign o_valid = r.valid;
	assign o_data = r.head;

endmodule : uartad_buf

`default_nettype wire

// file: tb/uartad_node.sv
`timescale 1ns/1ps
`default_nettype none

module uartad_node
(
	input wire logic i_clk, // system clock, paces the bit times
	output logic o_line // serial line toward the receiver
);

	// the line rests at mark level between characters
	initial o_line = 1'b1;

	// hold one level for n clocks, always changing 1 ns after an edge
	task automatic hold(input logic lvl, input int n);
		o_line = lvl;
		repeat (n) @(posedge i_clk);
		#1;
	endtask : hold

	// one character: low start, data lsb first, then the stop level;
	// a low stop is cut short; the receiver takes its tail for a start
	// that fails the mid-bit check, so no false character follows
	task automatic send(input logic [8:0] ch, input logic nine,
		input int bc, input logic stop_lvl);
		@(posedge i_clk);
		#1;
		hold(1'b0, bc);
		for (int i = 0; i < 9; i++)
		begin
			if (i < 8 || nine)
				hold(ch[i], bc);
		end
		if (stop_lvl)
			hold(1'b1, bc);
		else
		begin
			hold(1'b0, bc / 2 + 2);
			hold(1'b1, bc / 2);
		end
	endtask : send

endmodule : uartad_node

`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;

	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	wire logic line;
	logic [7:0] div_high = 8'h00;
	logic [7:0] div_low = 8'h01;
	logic hs = 1'b1;
	logic wide = 1'b1;
	logic port_en = 1'b0;
	logic sync = 1'b0;
	logic continuous_receive_enable = 1'b0;
	logic nine = 1'b0;
	logic addr = 1'b0;
	logic irq_en = 1'b0;
	logic data_read = 1'b0;
	wire logic [7:0] o_receive_data;
	wire logic o_ninth_bit;
	wire logic o_framing_error;
	wire logic o_overrun_error_flag;
	wire logic o_receive_irq_flag;
	wire logic o_receive_irq;
	wire logic o_receive_idle;
	wire logic [11:0] status;
	wire logic [11:0] flags;
	int mismatches = 0;
	int total_checks = 0;
	int bc = 8;
	// wide, high speed, divisor high, divisor low, clocks per bit
	int tbl [5][5] = '{'{0, 1, 8'hff, 0, 16}, '{0, 0, 0, 0, 64},
		'{1, 0, 0, 2, 48}, '{1, 1, 1, 0, 1028}, '{1, 1, 0, 1, 8}};

	// head of buffer packed with the sticky overrun flag and the receive flag for one compare
	assign status = {o_overrun_error_flag, o_receive_irq_flag,
		o_framing_error, o_ninth_bit, o_receive_data};
	// head data is unspecified once empty, so only flags are compared
	assign flags = {10'h000, o_overrun_error_flag, o_receive_irq_flag};

	uartad_node node (
		.i_clk(i_clk),
		.o_line(line)
	);

	uartad_rx uut (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_serial_receive_pin(line),
		.i_baud_divisor_high(div_high),
		.i_baud_divisor_low(div_low),
		.i_high_speed_baud_select(hs),
		.i_wide_divisor_select(wide),
		.i_serial_port_enable(port_en),
		.i_sync_mode_select(sync),
		.i_continuous_receive_enable(continuous_receive_enable),
		.i_nine_bit_receive_select(nine),
		.i_address_detect_enable(addr),
		.i_receive_irq_enable(irq_en),
		.i_data_read(data_read),
		.o_receive_data(o_receive_data),
		.o_ninth_bit(o_ninth_bit),
		.o_framing_error(o_framing_error),
		.o_overrun_error_flag(o_overrun_error_flag),
		.o_receive_irq_flag(o_receive_irq_flag),
		.o_receive_irq(o_receive_irq),
		.o_receive_idle(o_receive_idle)
	);

	// 100 ns period
	initial
	begin
		forever #50 i_clk = ~i_clk;
	end

	task automatic print_verdict();
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic cycles(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : cycles

	// send one character, then wait a bounded time for the idle state
	task automatic rx(input logic [8:0] ch, input logic stp);
		int k;
		node.send(ch, nine, bc, stp);
		k = 0;
		while (o_receive_idle !== 1'b1 && k < 200)
		begin
			cycles(1);
			k++;
		end
		if (k >= 200)
		begin
			mismatches++;
			$display("[FAIL] %0t receiver never idle", $time);
			print_verdict();
		end
		else
			cycles(2);
	endtask : rx

	// one-cycle read strobe pops the oldest entry
	task automatic rd();
		@(posedge i_clk);
		#1;
		data_read = 1'b1;
		cycles(1);
		data_read = 1'b0;
		cycles(1);
	endtask : rd

	initial
	begin
		cycles(10);
		i_rst = 1'b0;
		check({8'h00, flags[1:0], o_receive_irq, o_receive_idle}, 12'h001);
		port_en = 1'b1;
		continuous_receive_enable = 1'b1;
		irq_en = 1'b1;
		cycles(2);
		// plain eight-bit character, flagged and requesting
		rx(9'h0a5, 1'b1);
		check(status, {4'b0100, 8'ha5});
		check({11'h000, o_receive_irq}, 12'h001);
		irq_en = 1'b0;
		cycles(2);
		check({11'h000, o_receive_irq}, 12'h000);
		rd();
		check(flags, 12'h000);
		// address detect without nine-bit capture filters nothing
		addr = 1'b1;
		rx(9'h03c, 1'b1);
		check(status, {4'b0100, 8'h3c});
		rd();
		// address mode drops ninth-bit-zero characters
		nine = 1'b1;
		addr = 1'b1;
		rx(9'h033, 1'b1);
		check(flags, 12'h000);
		rx(9'h15a, 1'b1);
		check(status, {4'b0101, 8'h5a});
		rd();
		addr = 1'b0;
		rx(9'h044, 1'b1);
		check(status, {4'b0100, 8'h44});
		rd();
		rx(9'h1c3, 1'b0);
		check(status, {4'b0111, 8'hc3});
		rd();
		// third unread character overruns the two-entry buffer
		rx(9'h101, 1'b1);
		rx(9'h102, 1'b1);
		rx(9'h103, 1'b1);
		check(status, {4'b1101, 8'h01});
		rd();
		check(status, {4'b1101, 8'h02});
		rd();
		check(flags, 12'h002);
		continuous_receive_enable = 1'b0;
		cycles(2);
		check(flags, 12'h000);
		rx(9'h1aa, 1'b1);
		check(flags, 12'h000);
		continuous_receive_enable = 1'b1;
		port_en = 1'b0;
		rx(9'h1aa, 1'b1);
		check(flags, 12'h000);
		port_en = 1'b1;
		sync = 1'b1;
		rx(9'h1aa, 1'b1);
		check(flags, 12'h000);
		sync = 1'b0;
		// every speed select pairing and divisor width
		for (int i = 0; i < 5; i++)
		begin
			// the divider takes a new divisor at once only while stopped, so retune with reception off
			continuous_receive_enable = 1'b0;
			wide = 1'(tbl[i][0]);
			hs = 1'(tbl[i][1]);
			div_high = 8'(tbl[i][2]);
			div_low = 8'(tbl[i][3]);
			bc = tbl[i][4];
			cycles(2);
			continuous_receive_enable = 1'b1;
			cycles(2);
			rx(9'h130 + 9'(i), 1'b1);
			check(status, {4'b0101, 8'h30 + 8'(i)});
			rd();
		end
		print_verdict();
	end

endmodule : tb

`default_nettype wire
